// ==== itic_regs.svh ====
`ifndef ITIC_REGS_SVH
`define ITIC_REGS_SVH

// task-file offsets
`define ITIC_OFF_FEATURE    3'h1
`define ITIC_OFF_SECCNT     3'h2
`define ITIC_OFF_SECNUM     3'h3
`define ITIC_OFF_CYLLO      3'h4
`define ITIC_OFF_CYLHI      3'h5
`define ITIC_OFF_DRVHEAD    3'h6
`define ITIC_OFF_COMMAND    3'h7
// status read at the command offset
`define ITIC_STAT_BSY       7
`define ITIC_STAT_DRDY      6
// command codes
`define ITIC_CMD_IDLE_A     8'h97
`define ITIC_CMD_IDLE_B     8'hE3
`define ITIC_CMD_IDLEI_A    8'h95
`define ITIC_CMD_IDLEI_B    8'hE1
// identify word numbers served here
`define ITIC_W_ERASE        8'h59
`define ITIC_W_EERASE       8'h5A
`define ITIC_W_APM          8'h5B
`define ITIC_W_SEC          8'h80
`define ITIC_W_PWR          8'hA0
`define ITIC_W_KEY          8'hA2
`define ITIC_W_TRUEIDE      8'hA3
`define ITIC_W_PCMCIA       8'hA4
// timer tick: 5 ms at 50 MHz
`define ITIC_TICK_MS        5
`define ITIC_CLK_KHZ        50000
`define ITIC_TICK_CYC       (`ITIC_TICK_MS * `ITIC_CLK_KHZ)

`endif

// ==== itic_pkg.sv ====
package itic_pkg;
    typedef enum logic [1:0] {ITIC_IDLE, ITIC_BUSY, ITIC_DONE} itic_state_t;
    typedef logic [7:0]  itic_byte_t;
    typedef logic [15:0] itic_word_t;
endpackage : itic_pkg

// ==== itic_top.sv ====
// Behaviour
// - word 89 reports security erase time
// - word 90 reports enhanced erase time
// - word 91 low byte: APM level
// - word 128 bit 8: maximum security level
// - word 128 bit 5: enhanced erase supported
// - expired bit 4 aborts unlock until reset
// - bit 3 frozen, bit 2 locked
// - bit 1 enabled, bit 0 supported
// - word 160 bit 15 valid, bit 14 zero
// - bit 13 no level1, bit 12 disabled
// - word 160 low twelve bits: current mA
// - word 162 bit 0 key scheme support
// - word 163 bits 2-0 max PIO
// - word 163 bits 5-3 max DMA
// - word 163 bits 8-6 selected PIO
// - word 163 bits 11-9 selected DMA
// - word 164 bits 2-0 I/O cycle
// - word 164 bits 5-3 memory cycle
// - idle nonzero count arms 5 ms timer
// - idle zero count disables power-down
// - set busy, idle, clear, interrupt
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "itic_regs.svh"

module itic_top #(
    parameter int unsigned TICK_CYC = `ITIC_TICK_CYC,
    parameter logic [7:0]  ERASE_T  = 8'h00,
    parameter logic [7:0]  EERASE_T = 8'h00,
    parameter logic [11:0] MAX_MA   = 12'h064,
    parameter logic [2:0]  MAX_PIO  = 3'h2,
    parameter logic [2:0]  MAX_DMA  = 3'h2,
    parameter logic [2:0]  IO_CYC   = 3'h0,
    parameter logic [2:0]  MEM_CYC  = 3'h0
) (
    // clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst,
    // task-file port
    input  wire logic [2:0]        i_addr,
    input  wire itic_pkg::itic_byte_t i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output itic_pkg::itic_byte_t   o_rdata,
    // identify word lookup
    input  wire logic [7:0]        i_id_word,
    output itic_pkg::itic_word_t   o_id_data,
    output logic                   o_id_hit,
    // security and feature state from the core
    input  wire logic              i_sec_supported,
    input  wire logic              i_sec_enabled,
    input  wire logic              i_sec_max_level,
    input  wire logic              i_sec_frozen,
    input  wire logic              i_sec_locked,
    input  wire logic              i_sec_count_expired,
    input  wire logic              i_eerase_supported,
    input  wire logic              i_key_scheme_sup,
    input  wire logic              i_no_level1_power_cmds,
    input  wire logic              i_level1_power_cmds_disabled,
    input  wire logic [7:0]        i_apm_level,
    input  wire logic [2:0]        i_sel_pio,
    input  wire logic [2:0]        i_sel_dma,
    input  wire logic              i_sec_unlock_cmd,
    // results
    output logic                   o_sec_abort,
    output logic                   o_busy,
    output logic                   o_irq_pulse,
    output logic                   o_autopd_en,
    output logic                   o_power_down
);
    import itic_pkg::*;

    localparam int unsigned TW = $clog2(TICK_CYC + 1);

    itic_byte_t  feat_r, feat_nxt, cnt_r, cnt_nxt, num_r, num_nxt;
    itic_byte_t  cyll_r, cyll_nxt, cylh_r, cylh_nxt, dh_r, dh_nxt;
    itic_byte_t  rdata_r, rdata_nxt;
    itic_state_t st_r, st_nxt;
    logic        irq_r, irq_nxt, apd_r, apd_nxt, pd_r, pd_nxt;
    logic        exp_r, exp_nxt, abort_r, abort_nxt;
    itic_byte_t  tmo_r, tmo_nxt, left_r, left_nxt;
    logic [TW-1:0] tick_r, tick_nxt;
    itic_word_t  id_r, id_nxt;
    logic        hit_r, hit_nxt;
    logic        cmd_wr, is_idle, is_idlei;

    assign cmd_wr   = i_wr && (i_addr == `ITIC_OFF_COMMAND);
    assign is_idle  = (i_wdata == `ITIC_CMD_IDLE_A) || (i_wdata == `ITIC_CMD_IDLE_B);
    assign is_idlei = (i_wdata == `ITIC_CMD_IDLEI_A) || (i_wdata == `ITIC_CMD_IDLEI_B);

    // task-file writes and reads; status lives at the command offset
    always_comb begin
        feat_nxt  = feat_r;
        cnt_nxt   = cnt_r;
        num_nxt   = num_r;
        cyll_nxt  = cyll_r;
        cylh_nxt  = cylh_r;
        dh_nxt    = dh_r;
        rdata_nxt = 8'h00;
        if (i_wr) begin
            unique case (i_addr)
                `ITIC_OFF_FEATURE: feat_nxt = i_wdata;
                `ITIC_OFF_SECCNT:  cnt_nxt  = i_wdata;
                `ITIC_OFF_SECNUM:  num_nxt  = i_wdata;
                `ITIC_OFF_CYLLO:   cyll_nxt = i_wdata;
                `ITIC_OFF_CYLHI:   cylh_nxt = i_wdata;
                `ITIC_OFF_DRVHEAD: dh_nxt   = i_wdata;
                default: ;
            endcase
        end
        if (i_rd) begin
            unique case (i_addr)
                `ITIC_OFF_SECCNT:  rdata_nxt = cnt_r;
                `ITIC_OFF_SECNUM:  rdata_nxt = num_r;
                `ITIC_OFF_CYLLO:   rdata_nxt = cyll_r;
                `ITIC_OFF_CYLHI:   rdata_nxt = cylh_r;
                `ITIC_OFF_DRVHEAD: rdata_nxt = dh_r;
                `ITIC_OFF_COMMAND: begin
                    rdata_nxt = 8'h00;
                    rdata_nxt[`ITIC_STAT_BSY]  = (st_r == ITIC_BUSY);
                    rdata_nxt[`ITIC_STAT_DRDY] = (st_r != ITIC_BUSY);
                end
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // command sequencing and power-down timer
    always_comb begin
        st_nxt    = st_r;
        irq_nxt   = 1'b0;
        apd_nxt   = apd_r;
        pd_nxt    = pd_r;
        tmo_nxt   = tmo_r;
        left_nxt  = left_r;
        tick_nxt  = tick_r;
        exp_nxt   = exp_r | i_sec_count_expired;
        abort_nxt = i_sec_unlock_cmd && (exp_r || i_sec_count_expired);
        unique case (st_r)
            // busy one cycle; the interrupt rises as busy clears
            ITIC_BUSY: begin
                st_nxt  = ITIC_DONE;
                irq_nxt = 1'b1;
            end
            // interrupt pulse done, back to idle
            ITIC_DONE: st_nxt = ITIC_IDLE;
            ITIC_IDLE: ;
        endcase
        // timer ticks while armed and awake
        if (apd_r && !pd_r) begin
            if (tick_r == TW'(TICK_CYC - 1)) begin
                tick_nxt = '0;
                if (left_r <= 8'h01) begin
                    pd_nxt = 1'b1;
                end else begin
                    left_nxt = left_r - 8'h01;
                end
            end else begin
                tick_nxt = tick_r + TW'(1);
            end
        end
        if (cmd_wr) begin
            pd_nxt   = 1'b0;
            tick_nxt = '0;
            left_nxt = tmo_r;
            if (is_idle || is_idlei) begin
                st_nxt = ITIC_BUSY;
            end
            if (is_idle) begin
                // arm with count of 5 ms
                apd_nxt  = (cnt_r != 8'h00);
                tmo_nxt  = cnt_r;
                left_nxt = cnt_r;
            end
        end
    end

    // identify words served by this block
    always_comb begin
        id_nxt  = 16'h0000;
        hit_nxt = 1'b1;
        unique case (i_id_word)
            `ITIC_W_ERASE:  id_nxt = {8'h00, ERASE_T};
            `ITIC_W_EERASE: id_nxt = {8'h00, EERASE_T};
            `ITIC_W_APM:    id_nxt = {8'h00, i_apm_level};
            `ITIC_W_SEC:    id_nxt = {7'h00, i_sec_max_level, 2'h0, i_eerase_supported,
                                      exp_r, i_sec_frozen, i_sec_locked,
                                      i_sec_enabled, i_sec_supported};
            `ITIC_W_PWR:    id_nxt = {1'b1, 1'b0, i_no_level1_power_cmds,
                                      i_level1_power_cmds_disabled, MAX_MA};
            `ITIC_W_KEY:    id_nxt = {15'h0000, i_key_scheme_sup};
            `ITIC_W_TRUEIDE: id_nxt = {4'h0, i_sel_dma, i_sel_pio, MAX_DMA, MAX_PIO};
            `ITIC_W_PCMCIA: id_nxt = {10'h000, MEM_CYC, IO_CYC};
            default: hit_nxt = 1'b0;
        endcase
    end

    // register all state
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            feat_r  <= 8'h00;
            cnt_r   <= 8'h00;
            num_r   <= 8'h00;
            cyll_r  <= 8'h00;
            cylh_r  <= 8'h00;
            dh_r    <= 8'h00;
            rdata_r <= 8'h00;
            st_r    <= ITIC_IDLE;
            irq_r   <= 1'b0;
            apd_r   <= 1'b0;
            pd_r    <= 1'b0;
            exp_r   <= 1'b0;
            abort_r <= 1'b0;
            tmo_r   <= 8'h00;
            left_r  <= 8'h00;
            tick_r  <= '0;
            id_r    <= 16'h0000;
            hit_r   <= 1'b0;
        end else begin
            feat_r  <= feat_nxt;
            cnt_r   <= cnt_nxt;
            num_r   <= num_nxt;
            cyll_r  <= cyll_nxt;
            cylh_r  <= cylh_nxt;
            dh_r    <= dh_nxt;
            rdata_r <= rdata_nxt;
            st_r    <= st_nxt;
            irq_r   <= irq_nxt;
            apd_r   <= apd_nxt;
            pd_r    <= pd_nxt;
            exp_r   <= exp_nxt;
            abort_r <= abort_nxt;
            tmo_r   <= tmo_nxt;
            left_r  <= left_nxt;
            tick_r  <= tick_nxt;
            id_r    <= id_nxt;
            hit_r   <= hit_nxt;
        end
    end

    // outputs straight from flops, except busy, decoded from st_r
    assign o_rdata      = rdata_r;
    assign o_id_data    = id_r;
    assign o_id_hit     = hit_r;
    assign o_sec_abort  = abort_r;
    assign o_busy       = (st_r == ITIC_BUSY);
    assign o_irq_pulse  = irq_r;
    assign o_autopd_en  = apd_r;
    assign o_power_down = pd_r;

endmodule : itic_top

// ==== itic_asserts.sv ====
`timescale 1ns/1ps
module itic_asserts #(
    parameter logic [11:0] MAX_MA = 12'h064
) (
    // clock and reset
    input wire logic                 i_clk_sys,
    input wire logic                 i_rst,
    // task-file strobes
    input wire logic [2:0]           i_addr,
    input wire itic_pkg::itic_byte_t i_wdata,
    input wire logic                 i_wr,
    // identify lookup and security state
    input wire logic [7:0]           i_id_word,
    input wire logic                 i_sec_supported,
    input wire logic                 i_sec_enabled,
    input wire logic                 i_sec_max_level,
    input wire logic                 i_sec_frozen,
    input wire logic                 i_sec_locked,
    input wire logic                 i_eerase_supported,
    input wire logic                 i_sec_count_expired,
    input wire logic                 i_sec_unlock_cmd,
    // watched results
    input wire itic_pkg::itic_word_t o_id_data,
    input wire logic                 o_id_hit,
    input wire logic                 o_sec_abort,
    input wire logic                 o_busy,
    input wire logic                 o_irq_pulse,
    input wire logic                 o_power_down
);
    import itic_pkg::*;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // idle command decode, both code pairs
    wire cmd = i_wr && i_addr == 3'h7 && (i_wdata inside {8'h97, 8'hE3, 8'h95, 8'hE1});
    wire [3:0] sec4 = {i_sec_frozen, i_sec_locked, i_sec_enabled, i_sec_supported};
    // busy one cycle, then busy clear with the interrupt
    sequence s_busy_irq;
        o_busy ##1 (!o_busy && o_irq_pulse);
    endsequence
    a_busy_rise: assert property (cmd |=> o_busy)
        else $error("busy did not follow an idle command");
    a_idle_seq: assert property (cmd ##1 !i_wr |-> s_busy_irq)
        else $error("idle sequence out of order");
    a_irq_once: assert property (o_irq_pulse |=> !o_irq_pulse)
        else $error("interrupt pulse too long");
    a_pd_wake: assert property (i_wr && i_addr == 3'h7 |=> !o_power_down)
        else $error("command did not wake the card");
    a_abort_exp: assert property (i_sec_unlock_cmd && i_sec_count_expired |=> o_sec_abort)
        else $error("unlock not aborted after expiry");
    a_abort_cause: assert property (!i_sec_unlock_cmd |=> !o_sec_abort)
        else $error("abort without an attempt");
    a_w128_bits: assert property (i_id_word == 8'h80 |=> o_id_hit
        && o_id_data[8] == $past(i_sec_max_level) && o_id_data[5] == $past(i_eerase_supported)
        && o_id_data[3:0] == $past(sec4)) else $error("security word wrong");
    a_w160_fixed: assert property (i_id_word == 8'hA0 |=> o_id_hit
        && o_id_data[15:14] == 2'b10 && o_id_data[11:0] == MAX_MA)
        else $error("power word wrong");
    a_w_miss: assert property (!(i_id_word inside {8'h59, 8'h5A, 8'h5B, 8'h80, 8'hA0, 8'hA2,
        8'hA3, 8'hA4}) |=> !o_id_hit && o_id_data == 16'h0000)
        else $error("unserved word answered");
endmodule : itic_asserts

bind itic_top itic_asserts #(.MAX_MA(MAX_MA)) itic_asserts_i (.*);

// ==== itic_host.sv ====
`timescale 1ns/1ps
module itic_host (
    // clock
    input  wire logic                 i_clk_sys,
    // task-file master
    output logic [2:0]                o_addr,
    output itic_pkg::itic_byte_t      o_wdata,
    output logic                      o_wr,
    output logic                      o_rd,
    input  wire itic_pkg::itic_byte_t i_rdata
);
    import itic_pkg::*;
    // idle bus at time zero
    initial begin
        o_addr = 3'h0;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // one-cycle write; data inverted after release so stale values never match
    task automatic wr(input logic [2:0] a, input itic_byte_t d);
        @(posedge i_clk_sys);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk_sys);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output itic_byte_t d);
        @(posedge i_clk_sys);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk_sys);
        o_rd <= 1'b0;
        #1 d = i_rdata;
    endtask : rd
endmodule : itic_host

// ==== tb_itic_top.sv ====
`timescale 1ns/1ps
module tb_itic_top;
    import itic_pkg::*;
    logic i_clk_sys, i_rst, i_wr, i_rd, i_sec_supported, i_sec_enabled, i_sec_max_level;
    logic i_sec_frozen, i_sec_locked, i_sec_count_expired, i_eerase_supported, i_key_scheme_sup;
    logic i_no_level1_power_cmds, i_level1_power_cmds_disabled, i_sec_unlock_cmd, exl;
    logic o_id_hit, o_sec_abort, o_busy, o_irq_pulse, o_autopd_en, o_power_down;
    logic [2:0] i_addr, i_sel_pio, i_sel_dma;
    logic [7:0] i_apm_level, i_id_word, cd[$] = '{8'h97, 8'hE3, 8'h95, 8'hE1};
    itic_byte_t i_wdata, o_rdata, d;
    itic_word_t o_id_data;
    int fails = 0, comparisons = 0, seed = 74769, r, wq[$] = '{89, 90, 91, 128, 160, 162, 163, 164, 0, 92};
    itic_top #(.TICK_CYC(10)) itic_top_i (.*);
    itic_host itic_host_i (.i_clk_sys(i_clk_sys), .o_addr(i_addr), .o_wdata(i_wdata),
                           .o_wr(i_wr), .o_rd(i_rd), .i_rdata(o_rdata));
    // reference identify words from the chosen parameter defaults
    function automatic logic [15:0] exp_w(int w);
        case (w)
            91: exp_w = {8'h00, i_apm_level};
            128: exp_w = {7'h00, i_sec_max_level, 2'h0, i_eerase_supported, exl, i_sec_frozen,
                          i_sec_locked, i_sec_enabled, i_sec_supported};
            160: exp_w = {2'h2, i_no_level1_power_cmds, i_level1_power_cmds_disabled, 12'h064};
            162: exp_w = {15'h0000, i_key_scheme_sup};
            163: exp_w = {4'h0, i_sel_dma, i_sel_pio, 6'h12};
            default: exp_w = 16'h0000;
        endcase
    endfunction : exp_w
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic end_of_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    task automatic reset_all;
        i_rst <= 1'b1;
        repeat (10) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        exl = 1'b0;
        #1 chk(16'({o_busy, o_irq_pulse, o_autopd_en, o_power_down, o_sec_abort}), 16'h0000);
    endtask : reset_all
    task automatic idck(int w);
        @(posedge i_clk_sys);
        i_id_word <= w[7:0];
        @(posedge i_clk_sys);
        #1 chk(o_id_data, exp_w(w));
        chk(16'(o_id_hit), 16'(w inside {89, 90, 91, 128, 160, 162, 163, 164}));
    endtask : idck
    // unlock attempt and the abort it should or should not cause
    task automatic unlock(logic e);
        @(posedge i_clk_sys);
        i_sec_unlock_cmd <= 1'b1;
        @(posedge i_clk_sys);
        i_sec_unlock_cmd <= 1'b0;
        #1 chk(16'(o_sec_abort), 16'(e));
    endtask : unlock
    // 50 MHz clock
    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    // hang guard
    initial begin
        repeat (100000) @(posedge i_clk_sys);
        fails++;
        end_of_test;
    end
    initial begin
        {i_rst, i_id_word, i_sec_count_expired, i_sec_unlock_cmd} = 11'h400;
        {i_sec_supported, i_sec_enabled, i_sec_max_level, i_sec_frozen, i_sec_locked} = 5'h00;
        {i_eerase_supported, i_key_scheme_sup, i_no_level1_power_cmds} = 3'h0;
        {i_level1_power_cmds_disabled, i_apm_level, i_sel_pio, i_sel_dma} = 15'h0000;
        reset_all;
        // random core state against every served and some unserved words
        repeat (6) begin
            r = $random(seed);
            {i_sec_supported, i_sec_enabled, i_sec_max_level, i_sec_frozen, i_sec_locked,
             i_eerase_supported, i_key_scheme_sup, i_no_level1_power_cmds,
             i_level1_power_cmds_disabled, i_apm_level, i_sel_pio, i_sel_dma} <= r[22:0];
            foreach (wq[k]) idck(wq[k]);
        end
        $display("identify words done");
        // all four idle codes; zero count disarms, nonzero arms
        foreach (cd[k]) begin
            itic_host_i.wr(3'h2, 8'(k * 2));
            itic_host_i.wr(3'h7, cd[k]);
            #1 chk(16'(o_busy), 16'h0001);
            if (k < 2) chk(16'(o_autopd_en), 16'(k != 0));
            @(posedge i_clk_sys);
            #1 chk(16'({o_busy, o_irq_pulse}), 16'h0001);
        end
        $display("idle codes done");
        // count 2 at a 10-cycle tick: power-down at 20 cycles, a command wakes
        itic_host_i.wr(3'h2, 8'h02);
        itic_host_i.wr(3'h7, 8'h97);
        repeat (16) @(posedge i_clk_sys);
        #1 chk(16'(o_power_down), 16'h0000);
        repeat (8) @(posedge i_clk_sys);
        #1 chk(16'(o_power_down), 16'h0001);
        itic_host_i.wr(3'h7, 8'h00);
        #1 chk(16'(o_power_down), 16'h0000);
        itic_host_i.wr(3'h2, 8'h5A);
        itic_host_i.rd(3'h2, d);
        chk(16'(d), 16'h005A);
        itic_host_i.rd(3'h1, d);
        chk(16'(d), 16'h0000);
        itic_host_i.rd(3'h0, d);
        chk(16'(d), 16'h0000);
        itic_host_i.rd(3'h7, d);
        chk(16'(d), 16'h0040);
        $display("timer and registers done");
        // expiry latches until a reset and aborts unlock attempts
        unlock(1'b0);
        @(posedge i_clk_sys);
        i_sec_count_expired <= 1'b1;
        @(posedge i_clk_sys);
        i_sec_count_expired <= 1'b0;
        exl = 1'b1;
        idck(128);
        unlock(1'b1);
        reset_all;
        idck(128);
        unlock(1'b0);
        $display("expiry done");
        end_of_test;
    end
endmodule : tb_itic_top
